// *** logic/ppsm_top.sv ***
// peripheral pin select map with AXI4-Lite register access
`default_nettype none
module ppsm_top #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ppsm_pkg::ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [ppsm_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ppsm_pkg::ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [ppsm_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // device pins
  input wire logic [ppsm_pkg::NUM_PINS-1:0] pinIn,
  output logic [ppsm_pkg::NUM_PINS-1:0] pinOut,
  output logic [ppsm_pkg::NUM_PINS-1:0] pinOe,
  // port latches and direction control
  input wire logic [ppsm_pkg::NUM_PINS-1:0] pinOutputLatch,
  input wire logic [ppsm_pkg::NUM_PINS-1:0] pinDirectionControl,
  // peripheral outputs, bit k-1 belongs to output code k
  input wire logic [ppsm_pkg::NUM_OUT_SIG-1:0] periphOut,
  input wire logic [ppsm_pkg::NUM_OUT_SIG-1:0] periphDirOvrd,
  input wire logic [ppsm_pkg::NUM_OUT_SIG-1:0] periphOe,
  // peripheral inputs, one per input select register
  output logic [ppsm_pkg::NUM_IN-1:0] periphIn,
  // lock state
  output logic routingLocked
);
  localparam int PAD_W = ppsm_pkg::CODE_SPAN - ppsm_pkg::NUM_OUT_SIG - 1;
  localparam int PIN_PAD_W = ppsm_pkg::CODE_SPAN - ppsm_pkg::NUM_PINS;
  localparam int IN_PAD_W = ppsm_pkg::CODE_SPAN - ppsm_pkg::NUM_IN;
  localparam logic [ppsm_pkg::CODE_SPAN-1:0] OUT_SUPPORT =
    LARGE_VARIANT ? ppsm_pkg::OUT_SUPPORT_LARGE : ppsm_pkg::OUT_SUPPORT_SMALL;

  // ***************************************************************
  // state
  // ***************************************************************
  logic [ppsm_pkg::SEL_W-1:0] inSel_r [ppsm_pkg::NUM_IN];
  logic [ppsm_pkg::SEL_W-1:0] outSel_r [ppsm_pkg::NUM_PINS];
  logic routingLocked_r;
  logic [ppsm_pkg::NUM_PINS-1:0] pinMeta_r;
  logic [ppsm_pkg::NUM_PINS-1:0] pinSync_r;
  logic [ppsm_pkg::NUM_IN-1:0] periphIn_r;
  logic awHeld_r;
  logic wHeld_r;
  logic [ppsm_pkg::ADDR_W-1:0] awAddr_r;
  logic [ppsm_pkg::REG_W-1:0] wData_r;
  logic wLane0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [ppsm_pkg::DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;

  // ***************************************************************
  // implemented input selects per variant
  // ***************************************************************
  wire [ppsm_pkg::NUM_IN-1:0] inExists =
    LARGE_VARIANT ? {ppsm_pkg::NUM_IN{1'b1}} : ~ppsm_pkg::IN_LARGE_ONLY;
  wire [ppsm_pkg::CODE_SPAN-1:0] inExistsPad = {{IN_PAD_W{1'b0}}, inExists};

  // ***************************************************************
  // write decode
  // ***************************************************************
  wire [5:0] wrIdx = awAddr_r[7:2];
  wire wrInPage = (awAddr_r[11:8] == ppsm_pkg::IN_SEL_PAGE);
  wire wrOutPage = (awAddr_r[11:8] == ppsm_pkg::OUT_SEL_PAGE);
  wire wrInHit = wrInPage && (int'(wrIdx) < ppsm_pkg::NUM_IN);
  wire wrOutHit = wrOutPage && (int'(wrIdx) < ppsm_pkg::NUM_PINS);
  wire wrLockHit = (awAddr_r == ppsm_pkg::LOCK_ADDR);
  wire wrMapped = wrInHit || wrOutHit || wrLockHit;
  wire doWrite = awHeld_r && wHeld_r && !bvalid_r;
  wire wrEnable = doWrite && wLane0_r;
  wire selWriteOk = wrEnable && !routingLocked_r;
  wire inWriteOk = selWriteOk && wrInHit && inExistsPad[wrIdx];
  wire outWriteOk = selWriteOk && wrOutHit;

  assign s_axi_awready = !awHeld_r && !bvalid_r;
  assign s_axi_wready = !wHeld_r && !bvalid_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wHeld_r <= 1'b0;
      wData_r <= '0;
      wLane0_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata[ppsm_pkg::REG_W-1:0];
      wLane0_r <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= ppsm_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalid_r <= 1'b1;
      bresp_r <= wrMapped ? ppsm_pkg::RESP_OKAY : ppsm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ***************************************************************
  // selection registers
  // ***************************************************************
  // lock holds one bit
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      routingLocked_r <= 1'b0;
    end else if (wrEnable && wrLockHit) begin
      routingLocked_r <= wData_r[ppsm_pkg::LOCK_BIT];
    end
  end

  assign routingLocked = routingLocked_r;

  for (genvar k = 0; k < ppsm_pkg::NUM_IN; k++) begin : g_in_sel
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        inSel_r[k] <= ppsm_pkg::SEL_RESET;
      end else if (inWriteOk && (int'(wrIdx) == k)) begin
        inSel_r[k] <= wData_r[ppsm_pkg::SEL_W-1:0];
      end
    end
  end

  for (genvar p = 0; p < ppsm_pkg::NUM_PINS; p++) begin : g_out_sel
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        outSel_r[p] <= ppsm_pkg::SEL_RESET;
      end else if (outWriteOk && (int'(wrIdx) == p)) begin
        outSel_r[p] <= wData_r[ppsm_pkg::SEL_W-1:0];
      end
    end
  end

  // ***************************************************************
  // read decode
  // ***************************************************************
  wire [5:0] rdIdx = s_axi_araddr[7:2];
  wire rdInHit = (s_axi_araddr[11:8] == ppsm_pkg::IN_SEL_PAGE) &&
                 (int'(rdIdx) < ppsm_pkg::NUM_IN);
  wire rdOutHit = (s_axi_araddr[11:8] == ppsm_pkg::OUT_SEL_PAGE) &&
                  (int'(rdIdx) < ppsm_pkg::NUM_PINS);
  wire rdLockHit = (s_axi_araddr == ppsm_pkg::LOCK_ADDR);
  wire rdMapped = rdInHit || rdOutHit || rdLockHit;
  wire rdInLive = rdInHit && inExistsPad[rdIdx];
  wire [ppsm_pkg::SEL_W-1:0] rdSel =
    rdInLive ? inSel_r[rdIdx] : (rdOutHit ? outSel_r[rdIdx] : ppsm_pkg::SEL_RESET);
  wire [ppsm_pkg::DATA_W-1:0] rdWord =
    rdLockHit ? {{(ppsm_pkg::DATA_W-1){1'b0}}, routingLocked_r} :
                {{(ppsm_pkg::DATA_W-ppsm_pkg::SEL_W){1'b0}}, rdSel};
  wire arTake = s_axi_arvalid && !rvalid_r;

  assign s_axi_arready = !rvalid_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= ppsm_pkg::RESP_OKAY;
    end else if (arTake) begin
      rvalid_r <= 1'b1;
      rdata_r <= rdWord;
      rresp_r <= rdMapped ? ppsm_pkg::RESP_OKAY : ppsm_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ***************************************************************
  // input routing
  // ***************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end else begin
      pinMeta_r <= pinIn;
      pinSync_r <= pinMeta_r;
    end
  end

  // codes beyond the last pin select a low level
  wire [ppsm_pkg::CODE_SPAN-1:0] pinPad = {{PIN_PAD_W{1'b0}}, pinSync_r};

  for (genvar k = 0; k < ppsm_pkg::NUM_IN; k++) begin : g_in_route
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        periphIn_r[k] <= 1'b0;
      end else begin
        periphIn_r[k] <= inExists[k] & pinPad[inSel_r[k]];
      end
    end
  end

  assign periphIn = periphIn_r;

  // ***************************************************************
  // output routing
  // ***************************************************************
  wire [ppsm_pkg::CODE_SPAN-1:0] sigPad = {{PAD_W{1'b0}}, periphOut, 1'b0};
  wire [ppsm_pkg::CODE_SPAN-1:0] ovrdPad = {{PAD_W{1'b0}}, periphDirOvrd, 1'b0};
  wire [ppsm_pkg::CODE_SPAN-1:0] oePad = {{PAD_W{1'b0}}, periphOe, 1'b0};

  for (genvar p = 0; p < ppsm_pkg::NUM_PINS; p++) begin : g_pin
    ppsm_pin_mux u_pin (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .selCode(outSel_r[p]),
      .supportMask(OUT_SUPPORT),
      .sigPad(sigPad),
      .ovrdPad(ovrdPad),
      .oePad(oePad),
      .pinOutputLatch(pinOutputLatch[p]),
      .pinDirectionControl(pinDirectionControl[p]),
      .pinOut(pinOut[p]),
      .pinOe(pinOe[p])
    );
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  logic rdWasIn_r;
  logic rdWasLock_r;
  logic rdWasAbsent_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdWasIn_r <= 1'b0;
      rdWasLock_r <= 1'b0;
      rdWasAbsent_r <= 1'b0;
    end else if (arTake) begin
      rdWasIn_r <= rdInHit;
      rdWasLock_r <= rdLockHit;
      rdWasAbsent_r <= rdInHit && !inExistsPad[rdIdx];
    end
  end

  property p_upper_zero;
    @(posedge core_clk) disable iff (!rst_n)
    s_axi_rvalid |-> (s_axi_rdata[ppsm_pkg::DATA_W-1:ppsm_pkg::REG_W] == '0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

  property p_in_field;
    @(posedge core_clk) disable iff (!rst_n)
    (s_axi_rvalid && rdWasIn_r) |-> (s_axi_rdata[7:6] == 2'h0);
  endproperty
  a_in_field: assert property (p_in_field) else $error("input select bits 7:6 set");

  property p_lock_bits;
    @(posedge core_clk) disable iff (!rst_n)
    (s_axi_rvalid && rdWasLock_r) |-> (s_axi_rdata[7:1] == 7'h00);
  endproperty
  a_lock_bits: assert property (p_lock_bits) else $error("lock upper bits set");

  property p_absent_zero;
    @(posedge core_clk) disable iff (!rst_n)
    (s_axi_rvalid && rdWasAbsent_r) |-> (s_axi_rdata == '0);
  endproperty
  a_absent_zero: assert property (p_absent_zero) else $error("absent select reads nonzero");

  property p_route_in;
    @(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> (periphIn[0] == $past(pinPad[inSel_r[0]]));
  endproperty
  a_route_in: assert property (p_route_in) else $error("input route wrong");

  property p_locked_in;
    @(posedge core_clk) disable iff (!rst_n)
    routingLocked_r |=> $stable(inSel_r[0]) && $stable(outSel_r[0]);
  endproperty
  a_locked_in: assert property (p_locked_in) else $error("select changed while locked");

  property p_bresp_time;
    @(posedge core_clk) disable iff (!rst_n)
    (awHeld_r && wHeld_r && !bvalid_r) |=> s_axi_bvalid;
  endproperty
  a_bresp_time: assert property (p_bresp_time) else $error("write answer late");

  property p_rresp_time;
    @(posedge core_clk) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
  endproperty
  a_rresp_time: assert property (p_rresp_time) else $error("read answer late");

  c_write: cover property (@(posedge core_clk) disable iff (!rst_n) inWriteOk);
  c_locked_write: cover property (@(posedge core_clk) disable iff (!rst_n)
    wrEnable && wrInHit && routingLocked_r);
  c_read_lock: cover property (@(posedge core_clk) disable iff (!rst_n)
    s_axi_rvalid && rdWasLock_r && s_axi_rdata[0]);
endmodule : ppsm_top
`default_nettype wire

// *** logic/ppsm_pkg.sv ***
// constants and register map of the peripheral pin select map
`default_nettype none
package ppsm_pkg;
  // ***************************************************************
  // sizes
  // ***************************************************************
  localparam int NUM_PORTS = 5;
  localparam int PINS_PER_PORT = 8;
  localparam int NUM_PINS = NUM_PORTS * PINS_PER_PORT;
  localparam int SEL_W = 6;
  localparam int CODE_SPAN = 64;
  localparam int NUM_IN = 47;
  localparam int NUM_OUT_SIG = 49;
  localparam int REG_W = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // ***************************************************************
  // register map (byte addresses)
  // ***************************************************************
  localparam logic [3:0] IN_SEL_PAGE = 4'h0;
  localparam logic [3:0] OUT_SEL_PAGE = 4'h2;
  localparam logic [11:0] LOCK_ADDR = 12'h100;
  localparam int LOCK_BIT = 0;
  localparam logic [SEL_W-1:0] SEL_RESET = 6'h00;
  localparam logic [SEL_W-1:0] LATCH_CODE = 6'h00;
  // input select indices that only exist on the larger package
  localparam logic [NUM_IN-1:0] IN_LARGE_ONLY = 47'h0000_E008_8000;
  // output codes each variant supports; code 0 is the latch, handled apart
  localparam logic [CODE_SPAN-1:0] OUT_SUPPORT_LARGE = 64'h0003_FFFF_FFFF_FFFE;
  localparam logic [CODE_SPAN-1:0] OUT_SUPPORT_SMALL = 64'h0001_CFFE_EEE1_FFFE;
  // ***************************************************************
  // bus answers
  // ***************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ppsm_pkg
`default_nettype wire

// *** logic/ppsm_pin_mux.sv ***
// output selection and direction control for one pin
`default_nettype none
module ppsm_pin_mux (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // selection
  input wire logic [ppsm_pkg::SEL_W-1:0] selCode,
  input wire logic [ppsm_pkg::CODE_SPAN-1:0] supportMask,
  // peripheral side, indexed by output code
  input wire logic [ppsm_pkg::CODE_SPAN-1:0] sigPad,
  input wire logic [ppsm_pkg::CODE_SPAN-1:0] ovrdPad,
  input wire logic [ppsm_pkg::CODE_SPAN-1:0] oePad,
  // port side
  input wire logic pinOutputLatch,
  input wire logic pinDirectionControl,
  output logic pinOut,
  output logic pinOe
);
  logic pinOut_r;
  logic pinOe_r;
  wire isLatch = (selCode == ppsm_pkg::LATCH_CODE);
  wire supported = supportMask[selCode];
  wire takeOver = supported & ovrdPad[selCode];
  wire outNxt = isLatch ? pinOutputLatch : (supported & sigPad[selCode]);
  wire oeNxt = takeOver ? oePad[selCode] : ~pinDirectionControl;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pinOut_r <= 1'b0;
      pinOe_r <= 1'b0;
    end else begin
      pinOut_r <= outNxt;
      pinOe_r <= oeNxt;
    end
  end

  assign pinOut = pinOut_r;
  assign pinOe = pinOe_r;

  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_dir_override;
    @(posedge core_clk) disable iff (!rst_n)
    takeOver |=> (pinOe == $past(oePad[selCode]));
  endproperty
  a_dir_override: assert property (p_dir_override) else $error("override oe wrong");

  property p_unsupported_low;
    @(posedge core_clk) disable iff (!rst_n)
    (!isLatch && !supported) |=> !pinOut;
  endproperty
  a_unsupported_low: assert property (p_unsupported_low) else $error("unsupported not low");

  property p_latch_pass;
    @(posedge core_clk) disable iff (!rst_n)
    isLatch |=> (pinOut == $past(pinOutputLatch)) && (pinOe == !$past(pinDirectionControl));
  endproperty
  a_latch_pass: assert property (p_latch_pass) else $error("latch path wrong");

  c_override: cover property (@(posedge core_clk) disable iff (!rst_n) takeOver ##1 pinOe);
endmodule : ppsm_pin_mux
`default_nettype wire

// *** logic/ppsm_pkg_dummy_guard.sv ***
// intentionally empty compile unit
`default_nettype none
`default_nettype wire

// *** bench/ppsm_pin_model.sv ***
// pad model of the device pins seen from the board side
`default_nettype none
module ppsm_pin_model (
  // device side
  input wire logic [ppsm_pkg::NUM_PINS-1:0] pinOut,
  input wire logic [ppsm_pkg::NUM_PINS-1:0] pinOe,
  // board side
  input wire logic [ppsm_pkg::NUM_PINS-1:0] extLevel,
  output logic [ppsm_pkg::NUM_PINS-1:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pad shows the device level, otherwise the board level
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule : ppsm_pin_model
`default_nettype wire

// *** bench/tb_top.sv ***
// register and routing tests of the pin select map
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ***************************************************************
  // signals
  // ***************************************************************
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic bready = 1'b0, rready = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid, locked;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata, s2Rdata;
  logic [39:0] latchV = 40'h00_0000_0000, dirV = {40{1'b1}}, extLevel = 40'h00_0000_0000;
  logic [48:0] pOut = 49'h0, pOvrd = 49'h0, pOe = 49'h0;
  wire logic [39:0] pinIn, pinOut, pinOe, s2PinOut;
  wire logic [46:0] periphIn;
  logic [31:0] rd, rd2;
  logic [1:0] resp;
  int failures = 0;
  int nCompared = 0;
  always #4 core_clk = ~core_clk;
  // ***************************************************************
  // devices: large variant, small variant on the same bus inputs
  // ***************************************************************
  ppsm_top #(.LARGE_VARIANT(1'b1)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pinOutputLatch(latchV),
    .pinDirectionControl(dirV), .periphOut(pOut), .periphDirOvrd(pOvrd), .periphOe(pOe),
    .periphIn(periphIn), .routingLocked(locked));
  ppsm_top #(.LARGE_VARIANT(1'b0)) i_dut_small (.core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_bresp(),
    .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_araddr(araddr),
    .s_axi_rvalid(), .s_axi_rready(rready), .s_axi_rdata(s2Rdata), .s_axi_rresp(),
    .pinIn(pinIn), .pinOut(s2PinOut), .pinOe(), .pinOutputLatch(latchV),
    .pinDirectionControl(dirV), .periphOut(pOut), .periphDirOvrd(pOvrd), .periphOe(pOe),
    .periphIn(), .routingLocked());
  ppsm_pin_model i_pads (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn));
  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // handshakes are judged mid-cycle, where the slave's signals hold until the next edge
  task automatic axi_write(input logic [11:0] addr, input logic [31:0] data);
    logic awHit, wHit, bHit;
    awaddr <= addr;
    wdata <= data;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(negedge core_clk);
      awHit = awvalid && awready;
      wHit = wvalid && wready;
      bHit = bready && bvalid;
      if (bHit) resp = bresp;
      @(posedge core_clk);
      if (awHit) awvalid <= 1'b0;
      if (wHit) wvalid <= 1'b0;
      if (bHit) begin
        bready <= 1'b0;
        break;
      end
      // answer is awaited once both address and data are taken
      if ((awHit || !awvalid) && (wHit || !wvalid) && !bready) bready <= 1'b1;
    end
  endtask : axi_write
  task automatic axi_read(input logic [11:0] addr);
    logic arHit, rHit;
    araddr <= addr;
    arvalid <= 1'b1;
    forever begin
      @(negedge core_clk);
      arHit = arvalid && arready;
      rHit = rready && rvalid;
      if (rHit) begin
        rd = rdata;
        rd2 = s2Rdata;
        resp = rresp;
      end
      @(posedge core_clk);
      if (arHit) begin
        arvalid <= 1'b0;
        rready <= 1'b1;
      end
      if (rHit) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_read
  task automatic end_sim();
    $display("Compared %0d mismatches %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    axi_read(12'h100);
    chk("lock reset", 32'h0, rd);
    axi_read(12'h200);
    chk("out sel reset", 32'h0, rd);
    axi_write(12'h000, 32'h0000_00FF);
    axi_read(12'h000);
    chk("in sel width", 32'h3F, rd);
    // large-only select exists on one variant only
    axi_write(12'h03C, 32'h0000_0005);
    axi_read(12'h03C);
    chk("large only sel", 32'h05, rd);
    chk("small absent sel", 32'h00, rd2);
    axi_read(12'h0FC);
    chk("unmapped rdata", 32'h0, rd);
    chk("unmapped rresp", {30'h0, ppsm_pkg::RESP_SLVERR}, {30'h0, resp});
    axi_write(12'h0FC, 32'h0000_0001);
    chk("unmapped bresp", {30'h0, ppsm_pkg::RESP_SLVERR}, {30'h0, resp});
    // port C bit 3 as capture input, neighbours opposite
    axi_write(12'h030, 32'h0000_0013);
    extLevel <= 40'h00_0008_0000;
    repeat (5) @(posedge core_clk);
    chk("capture in high", 32'h1, {31'h0, periphIn[12]});
    extLevel <= ~40'h00_0008_0000;
    repeat (5) @(posedge core_clk);
    chk("capture in low", 32'h0, {31'h0, periphIn[12]});
    // latch path and peripheral direction takeover
    latchV <= 40'h00_0000_0005;
    dirV <= ~40'h00_0000_0001;
    pOut <= {49{1'b1}};
    pOvrd <= 49'h0_0000_0000_0010;
    pOe <= 49'h0_0000_0000_0010;
    axi_write(12'h204, 32'h0000_0005);
    axi_write(12'h208, 32'h0000_003F);
    axi_write(12'h20C, 32'h0000_0011);
    repeat (2) @(posedge core_clk);
    chk("latch out", 32'h1, {31'h0, pinOut[0]});
    chk("latch oe", 32'h1, {31'h0, pinOe[0]});
    chk("periph oe", 32'h1, {31'h0, pinOe[1]});
    chk("periph out", 32'h1, {31'h0, pinOut[1]});
    chk("bad code out", 32'h0, {31'h0, pinOut[2]});
    chk("large code out", 32'h1, {31'h0, pinOut[3]});
    chk("small code out", 32'h0, {31'h0, s2PinOut[3]});
    // lock freezes routing
    axi_write(12'h100, 32'h0000_00FF);
    axi_read(12'h100);
    chk("lock width", 32'h01, rd);
    chk("locked flag", 32'h1, {31'h0, locked});
    axi_write(12'h000, 32'h0000_0007);
    axi_write(12'h204, 32'h0000_0000);
    axi_read(12'h000);
    chk("locked in sel", 32'h3F, rd);
    repeat (2) @(posedge core_clk);
    chk("locked out sel", 32'h1, {31'h0, pinOe[1]});
    axi_write(12'h100, 32'h0000_0000);
    axi_write(12'h000, 32'h0000_0007);
    axi_read(12'h000);
    chk("unlocked in sel", 32'h07, rd);
    // a write without its low byte lane leaves the field alone
    wstrb <= 4'h0;
    axi_write(12'h000, 32'h0000_0009);
    chk("lane off bresp", {30'h0, ppsm_pkg::RESP_OKAY}, {30'h0, resp});
    wstrb <= 4'hF;
    axi_read(12'h000);
    chk("lane off in sel", 32'h07, rd);
    end_sim();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
